// *** src/button_debounce.sv ***
`timescale 1ns/1ps
module button_debounce #(
    parameter int STABLE_TICKS = 20
) (
    // Clock and reset
    input  wire logic mclk,
    input  wire logic rstn,
    input  wire logic tick,
    // Raw pin, active low
    input  wire logic rawN,
    // Cleaned level and press/release events
    output logic      pressed,
    output logic      pressPulse,
    output logic      releasePulse
);

    logic       sync1_q;
    logic       sync2_q;
    logic [7:0] count_q;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
        end else begin
            sync1_q <= ~rawN;
            sync2_q <= sync1_q;
        end
    end

    // Level must hold steady for the whole window before it is believed
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            count_q <= 8'h00;
            pressed <= 1'b0;
        end else if (sync2_q == pressed) begin
            count_q <= 8'h00;
        end else if (tick) begin
            if (count_q == 8'(STABLE_TICKS - 1)) begin
                pressed <= sync2_q;
                count_q <= 8'h00;
            end else begin
                count_q <= count_q + 8'h01;
            end
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            pressPulse   <= 1'b0;
            releasePulse <= 1'b0;
        end else begin
            pressPulse   <= tick && sync2_q && !pressed && count_q == 8'(STABLE_TICKS - 1);
            releasePulse <= tick && !sync2_q && pressed && count_q == 8'(STABLE_TICKS - 1);
        end
    end

endmodule : button_debounce

// *** src/tank_display_pkg.sv ***
package tank_display_pkg;

    localparam int CLK_HZ          = 25_000_000;
    localparam int ON_TIME_S       = 5;
    localparam int HOLD_LIMIT_S    = 300;
    localparam int REFRESH_S       = 1;
    localparam int DEBOUNCE_MS     = 20;
    localparam int BATTERY_VOLTAGE_BUTTON_REFRESH_MS = 250;
    localparam int TICK_MS         = 1;
    localparam int TICK_CYCLES     = CLK_HZ / 1000 * TICK_MS;
    localparam int ON_TIME_MS      = ON_TIME_S * 1000;
    localparam int HOLD_LIMIT_MS   = HOLD_LIMIT_S * 1000;
    localparam int REFRESH_MS      = REFRESH_S * 1000;

    localparam int NUM_BUTTONS     = 4;
    localparam int BTN_FRESH       = 0;
    localparam int BTN_GREY        = 1;
    localparam int BTN_BLACK       = 2;
    localparam int BTN_BATTERY_VOLTAGE_BUTTON        = 3;

    localparam logic [6:0] LEVEL_FULL  = 7'h64;
    localparam logic [3:0] ERR_NONE    = 4'h0;

    typedef enum logic [1:0] {
        SRC_FRESH,
        SRC_GREY,
        SRC_BLACK,
        SRC_BATTERY
    } source_type;

    // One sender report as delivered by the shared-wire receiver
    typedef struct packed {
        logic       valid;
        logic       checkOk;
        logic [1:0] tank;
        logic [6:0] level;
        logic [7:0] signalPower;
        logic [3:0] errCode;
    } report_type;

    // Readout contents; the digit decoder lives downstream
    typedef struct packed {
        logic       on;
        logic       battery;
        logic       error;
        logic [1:0] tank;
        logic [9:0] value;
        logic [3:0] errCode;
        logic       holdPoint;
        logic       diag;
    } readout_type;

endpackage : tank_display_pkg

// *** src/tank_level_display_control.sv ***
`timescale 1ns/1ps
module tank_level_display_control
    import tank_display_pkg::*;
#(
    parameter int ON_TIME_TICKS    = ON_TIME_MS,
    parameter int HOLD_LIMIT_TICKS = HOLD_LIMIT_MS,
    parameter int REFRESH_TICKS    = REFRESH_MS,
    parameter int BATTERY_VOLTAGE_BUTTON_TICKS       = BATTERY_VOLTAGE_BUTTON_REFRESH_MS,
    parameter int DEBOUNCE_TICKS   = DEBOUNCE_MS,
    parameter int TICK_LEN         = TICK_CYCLES
) (
    // Clock and reset
    input  wire logic                         mclk,
    input  wire logic                         rstn,
    // Front-panel buttons, active low
    input  wire logic [NUM_BUTTONS-1:0]       buttonN,
    // Sender reports from the shared-wire receiver
    input  wire tank_display_pkg::report_type report,
    // Battery measurement
    output logic                              battMeasureReq,
    input  wire logic                         battMeasureDone,
    input  wire logic [9:0]                   battDeciVolts,
    // Level refresh request towards the receiver
    output logic                              levelRefreshReq,
    output logic [1:0]                        levelRefreshTank,
    // Readout
    output tank_display_pkg::readout_type     readout
);
    import tank_display_pkg::*;

    typedef enum logic [2:0] {
        ST_OFF,
        ST_SHOW,
        ST_HOLD,
        ST_DIAG
    } mode_type;

    localparam int CNT_W = 20;

    logic                   tick;
    logic [15:0]            tickCnt_q;
    logic [NUM_BUTTONS-1:0] down;
    logic [NUM_BUTTONS-1:0] press;
    logic [NUM_BUTTONS-1:0] rel;
    mode_type               mode_q;
    source_type             src_q;
    logic                   holdArm_q;
    logic [CNT_W-1:0]       onCnt_q;
    logic [CNT_W-1:0]       holdCnt_q;
    logic [CNT_W-1:0]       refCnt_q;
    logic [6:0]             level_q [3];
    logic [3:0]             err_q [3];
    logic [9:0]             battery_voltage_button_q;
    logic                   anyPress;
    logic                   twoDown;
    logic                   tankPress;
    logic [1:0]             pressIdx;

    function automatic logic [1:0] firstSet(input logic [NUM_BUTTONS-1:0] v);
        logic [1:0] r;
        r = 2'h0;
        for (int i = NUM_BUTTONS - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = 2'(i);
            end
        end
        return r;
    endfunction : firstSet

    function automatic logic [2:0] popCount(input logic [NUM_BUTTONS-1:0] v);
        logic [2:0] r;
        r = 3'h0;
        for (int i = 0; i < NUM_BUTTONS; i++) begin
            r = r + {2'h0, v[i]};
        end
        return r;
    endfunction : popCount

    // Millisecond tick shared by every timer
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            tickCnt_q <= 16'h0000;
            tick      <= 1'b0;
        end else if (tickCnt_q == 16'(TICK_LEN - 1)) begin
            tickCnt_q <= 16'h0000;
            tick      <= 1'b1;
        end else begin
            tickCnt_q <= tickCnt_q + 16'h0001;
            tick      <= 1'b0;
        end
    end

    // Only these four inputs steer the modes; reports and battery readings only fill the readout
    generate
        for (genvar b = 0; b < NUM_BUTTONS; b++) begin : g_btn
            button_debounce #(
                .STABLE_TICKS (DEBOUNCE_TICKS)
            ) u_deb (
                .mclk         (mclk),
                .rstn         (rstn),
                .tick         (tick),
                .rawN         (buttonN[b]),
                .pressed      (down[b]),
                .pressPulse   (press[b]),
                .releasePulse (rel[b])
            );
        end
    endgenerate

    assign anyPress  = |press;
    assign twoDown   = popCount(down) >= 3'h2;
    assign tankPress = |press[BTN_BLACK:BTN_FRESH];
    assign pressIdx  = firstSet(press);

    // Mode sequencing
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            mode_q    <= ST_OFF;
            src_q     <= SRC_FRESH;
            holdArm_q <= 1'b0;
        end else begin
            unique case (mode_q)
                ST_OFF, ST_SHOW: begin
                    if (twoDown) begin
                        mode_q <= ST_DIAG;
                    end else if (anyPress) begin
                        // Same tank again while shown arms hold for the release
                        holdArm_q <= mode_q == ST_SHOW && src_q == source_type'(pressIdx)
                                     && pressIdx != 2'(BTN_BATTERY_VOLTAGE_BUTTON);
                        src_q     <= source_type'(pressIdx);
                        mode_q    <= ST_SHOW;
                    end else if (holdArm_q && rel[src_q]) begin
                        mode_q    <= ST_HOLD;
                        holdArm_q <= 1'b0;
                    end else if (mode_q == ST_SHOW && !down[src_q] && !holdArm_q
                                 && onCnt_q == CNT_W'(ON_TIME_TICKS)) begin
                        mode_q <= ST_OFF;
                    end
                end
                ST_HOLD: begin
                    if (twoDown) begin
                        mode_q <= ST_DIAG;
                    end else if (tankPress || holdCnt_q == CNT_W'(HOLD_LIMIT_TICKS)) begin
                        mode_q <= ST_OFF;
                    end else if (press[BTN_BATTERY_VOLTAGE_BUTTON]) begin
                        src_q  <= SRC_BATTERY;
                        mode_q <= ST_SHOW;
                    end
                end
                ST_DIAG: begin
                    // Leaves once every button is up; the sub-menus are not built
                    if (down == '0) begin
                        mode_q    <= ST_OFF;
                        holdArm_q <= 1'b0;
                    end
                end
                default: mode_q <= ST_OFF;
            endcase
        end
    end

    // On-time counter, restarted by any press
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            onCnt_q <= '0;
        end else if (anyPress || mode_q != ST_SHOW || down[src_q]) begin
            onCnt_q <= '0;
        end else if (tick && onCnt_q != CNT_W'(ON_TIME_TICKS)) begin
            onCnt_q <= onCnt_q + 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            holdCnt_q <= '0;
        end else if (mode_q != ST_HOLD) begin
            holdCnt_q <= '0;
        end else if (tick && holdCnt_q != CNT_W'(HOLD_LIMIT_TICKS)) begin
            holdCnt_q <= holdCnt_q + 1'b1;
        end
    end

    // Periodic refresh: one second in hold, faster while battery held
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            refCnt_q         <= '0;
            levelRefreshReq  <= 1'b0;
            levelRefreshTank <= 2'h0;
            battMeasureReq   <= 1'b0;
        end else begin
            levelRefreshReq <= 1'b0;
            battMeasureReq  <= 1'b0;
            if (anyPress) begin
                // A tank press in hold only blanks, so no fresh reading is fetched
                refCnt_q         <= '0;
                levelRefreshReq  <= pressIdx != 2'(BTN_BATTERY_VOLTAGE_BUTTON) && mode_q != ST_HOLD;
                levelRefreshTank <= pressIdx;
                battMeasureReq   <= pressIdx == 2'(BTN_BATTERY_VOLTAGE_BUTTON);
            end else if (mode_q == ST_HOLD) begin
                if (tick) begin
                    if (refCnt_q == CNT_W'(REFRESH_TICKS - 1)) begin
                        refCnt_q         <= '0;
                        levelRefreshReq  <= 1'b1;
                        levelRefreshTank <= 2'(src_q);
                    end else begin
                        refCnt_q <= refCnt_q + 1'b1;
                    end
                end
            end else if (mode_q == ST_SHOW && src_q == SRC_BATTERY && down[BTN_BATTERY_VOLTAGE_BUTTON]) begin
                if (tick) begin
                    if (refCnt_q == CNT_W'(BATTERY_VOLTAGE_BUTTON_TICKS - 1)) begin
                        refCnt_q       <= '0;
                        battMeasureReq <= 1'b1;
                    end else begin
                        refCnt_q <= refCnt_q + 1'b1;
                    end
                end
            end else begin
                refCnt_q <= '0;
            end
        end
    end

    // Stored readings; a report failing its check is dropped
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            for (int t = 0; t < 3; t++) begin
                level_q[t] <= 7'h00;
                err_q[t]   <= ERR_NONE;
            end
        end else if (report.valid && report.checkOk && report.tank != 2'h3) begin
            err_q[report.tank] <= report.errCode;
            if (report.errCode == ERR_NONE) begin
                level_q[report.tank] <= (report.level > LEVEL_FULL) ? LEVEL_FULL
                                                                    : report.level;
            end
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            battery_voltage_button_q <= 10'h000;
        end else if (battMeasureDone) begin
            battery_voltage_button_q <= battDeciVolts;
        end
    end

    // Registered readout
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            readout <= '0;
        end else begin
            readout.on        <= mode_q != ST_OFF;
            readout.diag      <= mode_q == ST_DIAG;
            readout.battery   <= src_q == SRC_BATTERY;
            readout.tank      <= 2'(src_q);
            readout.holdPoint <= mode_q == ST_HOLD;
            if (src_q == SRC_BATTERY) begin
                readout.value   <= battery_voltage_button_q;
                readout.error   <= 1'b0;
                readout.errCode <= ERR_NONE;
            end else begin
                readout.value   <= {3'h0, level_q[src_q]};
                readout.error   <= err_q[src_q] != ERR_NONE;
                readout.errCode <= err_q[src_q];
            end
        end
    end

endmodule : tank_level_display_control

// *** testbench/sender_model.sv ***
`timescale 1ns/1ps
module sender_model (
    // Clock and reset
    input  wire logic                         mclk,
    input  wire logic                         rstn,
    // Requests from the block
    input  wire logic                         levelRefreshReq,
    input  wire logic [1:0]                   levelRefreshTank,
    input  wire logic                         battMeasureReq,
    // Bench settings
    input  wire logic [2:0][6:0]              lvl,
    input  wire logic                         badCheck,
    input  wire logic [3:0]                   fault,
    input  wire logic [9:0]                   volts,
    // Answers
    output tank_display_pkg::report_type      report,
    output logic                              battMeasureDone,
    output logic [9:0]                        battDeciVolts
);
    import tank_display_pkg::*;

    logic [2:0] levelDly_q;
    logic [1:0] battDly_q;
    logic [1:0] tank_q;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            levelDly_q <= '0;
            battDly_q  <= '0;
            tank_q     <= '0;
        end else begin
            levelDly_q <= {levelDly_q[1:0], levelRefreshReq};
            battDly_q  <= {battDly_q[0], battMeasureReq};
            if (levelRefreshReq) begin
                tank_q <= levelRefreshTank;
            end
        end
    end

    // One report bus carries every tank, told apart by its tank field
    assign report.valid       = levelDly_q[2];
    assign report.checkOk     = !badCheck;
    assign report.tank        = tank_q;
    // Stale data is inverted so nothing can latch it by luck
    assign report.level       = levelDly_q[2] ? lvl[tank_q] : ~lvl[tank_q];
    assign report.signalPower = 8'h5a;
    assign report.errCode     = fault;
    assign battMeasureDone    = battDly_q[1];
    assign battDeciVolts      = battDly_q[1] ? volts : ~volts;
endmodule : sender_model

// *** testbench/tank_display_asserts.sv ***
`timescale 1ns/1ps
module tank_display_asserts #(
    parameter int ON_TIME_TICKS    = 50,
    parameter int HOLD_LIMIT_TICKS = 500,
    parameter int REFRESH_TICKS    = 10,
    parameter int TICK_LEN         = 4
) (
    // Clock and reset
    input  wire logic                         mclk,
    input  wire logic                         rstn,
    // Watched ports
    input  wire logic [3:0]                   buttonN,
    input  wire tank_display_pkg::report_type report,
    input  wire logic                         battMeasureReq,
    input  wire logic                         levelRefreshReq,
    input  wire logic [1:0]                   levelRefreshTank,
    input  wire tank_display_pkg::readout_type readout
);
    import tank_display_pkg::*;

    // Slack covers debounce delay and tick alignment
    localparam int ON_LIM   = ON_TIME_TICKS * TICK_LEN + 64;
    localparam int HOLD_LIM = HOLD_LIMIT_TICKS * TICK_LEN + 64;
    localparam int REF_LIM  = REFRESH_TICKS * TICK_LEN + 16;

    logic [15:0] onCnt_q;
    logic [15:0] holdCnt_q;
    logic [15:0] refCnt_q;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            onCnt_q <= '0;
        end else if (readout.on && !readout.holdPoint && !readout.diag && &buttonN) begin
            onCnt_q <= onCnt_q + 16'h1;
        end else begin
            onCnt_q <= '0;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            holdCnt_q <= '0;
        end else begin
            holdCnt_q <= readout.holdPoint ? holdCnt_q + 16'h1 : 16'h0;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            refCnt_q <= '0;
        end else begin
            refCnt_q <= (readout.holdPoint && !levelRefreshReq) ? refCnt_q + 16'h1 : 16'h0;
        end
    end

    a_on_time_bound: assert property (int'(onCnt_q) <= ON_LIM)
        else $error("readout stayed on past the on-time");
    a_hold_limit_bound: assert property (int'(holdCnt_q) <= HOLD_LIM)
        else $error("hold mode outlived its limit");
    a_hold_refresh_gap: assert property (int'(refCnt_q) <= REF_LIM)
        else $error("hold refresh gap too long");
    a_refresh_held_tank: assert property (levelRefreshReq && readout.holdPoint
        |-> levelRefreshTank == readout.tank)
        else $error("hold refresh asked for the wrong tank");
    a_hold_point_shown: assert property (readout.holdPoint |-> readout.on)
        else $error("hold point lit on a blank readout");
    a_hold_entry_ok: assert property ($rose(readout.holdPoint)
        |-> $past(readout.on) && !readout.battery)
        else $error("hold entered from a wrong state");
    a_battery_voltage_button_no_hold: assert property (readout.battery |-> !readout.holdPoint)
        else $error("battery reading in hold mode");
    a_level_in_range: assert property (readout.on && !readout.battery && !readout.error
        && !readout.diag |-> readout.value <= 10'h064)
        else $error("level above full");
    a_tank_legal_only: assert property (readout.on && !readout.battery
        |-> readout.tank != 2'h3)
        else $error("readout shows a tank without a button");
    a_battery_voltage_button_req_pulse: assert property (battMeasureReq |=> !battMeasureReq)
        else $error("measure request longer than one cycle");
    a_error_shown: assert property (report.valid && report.checkOk && report.errCode != 4'h0
        && report.tank == readout.tank && readout.on && !readout.battery
        |-> ##[1:4] readout.error)
        else $error("sender fault not shown");
endmodule : tank_display_asserts

bind tank_level_display_control tank_display_asserts #(
    .ON_TIME_TICKS(ON_TIME_TICKS),
    .HOLD_LIMIT_TICKS(HOLD_LIMIT_TICKS),
    .REFRESH_TICKS(REFRESH_TICKS),
    .TICK_LEN(TICK_LEN)
) checker_i (
    .mclk(mclk), .rstn(rstn), .buttonN(buttonN), .report(report),
    .battMeasureReq(battMeasureReq), .levelRefreshReq(levelRefreshReq),
    .levelRefreshTank(levelRefreshTank), .readout(readout)
);

// *** testbench/tb_tank_level_display_control.sv ***
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_errors++; \
    $display("wrong value t=%0t got %h exp %h", $time, (a), (b)); end end
`define WAITC(c, n) begin for (k = 0; k < (n) && !(c); k++) @(negedge mclk); \
    `CHK(c, 1'b1) if (!(c)) results(); end
module tb_tank_level_display_control;
    import tank_display_pkg::*;

    localparam int T    = 4;
    localparam int ON   = 50 * T;
    localparam int HOLD = 500 * T;

    logic            mclk;
    logic            rstn;
    logic [3:0]      buttonN;
    report_type      report;
    logic            battMeasureReq;
    logic            battMeasureDone;
    logic [9:0]      battDeciVolts;
    logic            levelRefreshReq;
    logic [1:0]      levelRefreshTank;
    readout_type     readout;
    logic [2:0][6:0] lvl;
    logic            badCheck;
    logic [3:0]      fault;
    logic [9:0]      volts;
    int              n_errors;
    int              samples_checked;
    int              k;

    tank_level_display_control #(
        .ON_TIME_TICKS(50), .HOLD_LIMIT_TICKS(500), .REFRESH_TICKS(10),
        .BATTERY_VOLTAGE_BUTTON_TICKS(5), .DEBOUNCE_TICKS(2), .TICK_LEN(T)
    ) DUT (
        .mclk(mclk), .rstn(rstn), .buttonN(buttonN), .report(report),
        .battMeasureReq(battMeasureReq), .battMeasureDone(battMeasureDone),
        .battDeciVolts(battDeciVolts), .levelRefreshReq(levelRefreshReq),
        .levelRefreshTank(levelRefreshTank), .readout(readout)
    );

    sender_model partner (
        .mclk(mclk), .rstn(rstn), .levelRefreshReq(levelRefreshReq),
        .levelRefreshTank(levelRefreshTank), .battMeasureReq(battMeasureReq),
        .lvl(lvl), .badCheck(badCheck), .fault(fault), .volts(volts),
        .report(report), .battMeasureDone(battMeasureDone), .battDeciVolts(battDeciVolts)
    );

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    task automatic results;
        if (n_errors == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : results

    // Press long enough to pass debounce, then let it settle
    task automatic tap(input logic [3:0] m);
        buttonN = ~m;
        repeat (30) @(negedge mclk);
        buttonN = 4'hf;
        repeat (30) @(negedge mclk);
    endtask : tap

    task automatic checkGlitch;
        buttonN = 4'hd;
        @(negedge mclk);
        buttonN = 4'hf;
        repeat (30) @(negedge mclk);
        `CHK(readout.on, 1'b0)
    endtask : checkGlitch

    task automatic checkShow;
        lvl[1] = 7'h2a;
        lvl[2] = 7'h64;
        tap(4'h2);
        `CHK(readout.on, 1'b1)
        `CHK(readout.tank, 2'h1)
        `CHK(readout.value, 10'h02a)
        repeat (100) @(negedge mclk);
        tap(4'h4);
        `CHK(readout.tank, 2'h2)
        `CHK(readout.value, 10'h064)
        repeat (ON - 60) @(negedge mclk);
        `CHK(readout.on, 1'b1)
        `WAITC(!readout.on, 100)
    endtask : checkShow

    task automatic checkHold;
        lvl[0] = 7'h10;
        tap(4'h1);
        tap(4'h1);
        `CHK(readout.holdPoint, 1'b1)
        `CHK(readout.tank, 2'h0)
        lvl[0] = 7'h11;
        repeat (60) @(negedge mclk);
        `CHK(readout.value, 10'h011)
        tap(4'h2);
        `CHK(readout.on, 1'b0)
        `CHK(readout.holdPoint, 1'b0)
    endtask : checkHold

    task automatic checkHoldLimit;
        tap(4'h4);
        tap(4'h4);
        `CHK(readout.holdPoint, 1'b1)
        repeat (HOLD - 100) @(negedge mclk);
        `CHK(readout.on, 1'b1)
        `WAITC(!readout.on, 200)
    endtask : checkHoldLimit

    task automatic checkBattery;
        volts = 10'h07e;
        buttonN = 4'h7;
        repeat (30) @(negedge mclk);
        `CHK(readout.battery, 1'b1)
        `CHK(readout.value, 10'h07e)
        volts = 10'h07f;
        repeat (60) @(negedge mclk);
        `CHK(readout.value, 10'h07f)
        buttonN = 4'hf;
        repeat (30) @(negedge mclk);
        tap(4'h8);
        `CHK(readout.holdPoint, 1'b0)
        `CHK(readout.on, 1'b1)
        `WAITC(!readout.on, ON + 100)
    endtask : checkBattery

    task automatic checkDiag;
        buttonN = 4'hc;
        repeat (30) @(negedge mclk);
        `CHK(readout.diag, 1'b1)
        buttonN = 4'hf;
        repeat (30) @(negedge mclk);
        `CHK(readout.on, 1'b0)
    endtask : checkDiag

    task automatic checkErrors;
        badCheck = 1'b1;
        lvl[2] = 7'h05;
        tap(4'h4);
        `CHK(readout.value, 10'h064)
        `WAITC(!readout.on, ON + 100)
        badCheck = 1'b0;
        fault = 4'h3;
        tap(4'h4);
        `CHK(readout.error, 1'b1)
        `CHK(readout.errCode, 4'h3)
        fault = 4'h0;
        `WAITC(!readout.on, ON + 100)
    endtask : checkErrors

    initial begin
        rstn = 1'b0;
        buttonN = 4'hf;
        lvl = '0;
        badCheck = 1'b0;
        fault = 4'h0;
        volts = 10'h000;
        n_errors = 0;
        samples_checked = 0;
        repeat (6) @(negedge mclk);
        rstn = 1'b1;
        repeat (4) @(negedge mclk);
        checkGlitch();
        checkShow();
        checkHold();
        checkHoldLimit();
        checkBattery();
        checkDiag();
        checkErrors();
        results();
    end

    // Hang guard
    initial begin
        repeat (100000) @(posedge mclk);
        n_errors++;
        results();
    end
endmodule : tb_tank_level_display_control
